// >>> src/dgc_top.sv
// DMA controller global control: arbitration policy, controller enable,
// software request and last flags, interrupt mask, status and line.
// Assumes an AHB-Lite slave slot, and channel logic that reports events
// as one-cycle pulses and acknowledges consumed requests.
`timescale 1ns/1ps

module dgc_top
	import dgc_pkg::*;
(
	input  wire logic              SYS_CLK_I,
	input  wire logic              RST_B_I,
	input  wire logic              HSEL_I,
	input  wire logic [31:0]       HADDR_I,
	input  wire logic [1:0]        HTRANS_I,
	input  wire logic              HWRITE_I,
	input  wire logic [2:0]        HSIZE_I,
	input  wire logic              HREADY_I,
	input  wire logic [31:0]       HWDATA_I,
	output logic      [31:0]       HRDATA_O,
	output logic                   HREADYOUT_O,
	output logic                   HRESP_O,
	input  wire logic              WRITE_PROTECT_ON_I,
	input  wire dgc_evt_t          EVT_I,
	input  wire logic [REQ_W-1:0]  SINGLE_DONE_I,
	input  wire logic [REQ_W-1:0]  CHUNK_DONE_I,
	output logic                   ARB_POLICY_SEL_O,
	output logic                   CTRL_ENABLE_O,
	output logic      [REQ_W-1:0]  SINGLE_REQ_O,
	output logic      [REQ_W-1:0]  CHUNK_REQ_O,
	output logic      [REQ_W-1:0]  FINAL_MARKER_O,
	output logic                   IRQ_O
);

	// ****************************************
	// Bus front end
	// ****************************************
	dgc_aph_t          aph;
	dgc_aph_t          next_aph;
	logic [31:0]       rdata;
	logic [31:0]       next_rdata;
	logic              addr_take;
	logic              rd_take;

	// ****************************************
	// Register state
	// ****************************************
	logic [GCFG_W-1:0] gcfg;
	logic [GCFG_W-1:0] next_gcfg;
	logic              ctrl_ena;
	logic              next_ctrl_ena;
	logic [REQ_W-1:0]  sreq;
	logic [REQ_W-1:0]  next_sreq;
	logic [REQ_W-1:0]  creq;
	logic [REQ_W-1:0]  next_creq;
	logic [REQ_W-1:0]  last;
	logic [REQ_W-1:0]  next_last;
	dgc_evt_t          mask;
	dgc_evt_t          next_mask;
	dgc_evt_t          stat;
	dgc_evt_t          next_stat;
	logic              irq;
	logic              next_irq;

	// Write strobes decoded from the captured address phase
	logic              wr_gcfg;
	logic              wr_ena;
	logic              wr_sreq;
	logic              wr_creq;
	logic              wr_last;
	logic              wr_iena;
	logic              wr_idis;

	// ****************************************
	// Address phase and read data
	// ****************************************
	always_comb begin
		addr_take = HSEL_I & HTRANS_I[1] & HREADY_I;
		rd_take   = addr_take & ~HWRITE_I;
		next_aph.valid = addr_take;
		next_aph.write = HWRITE_I;
		next_aph.addr  = HADDR_I;
		// Read data is fetched in the address phase so it stands for
		// the whole zero-wait data phase; unmapped words read zero.
		next_rdata = WORD_0;
		if (rd_take) begin
			unique case (HADDR_I)
				ADDR_GCFG: begin
					next_rdata[GCFG_W-1:0] = gcfg;
				end
				ADDR_ENA: begin
					next_rdata[ENA_BIT] = ctrl_ena;
				end
				ADDR_SREQ: begin
					next_rdata[REQ_W-1:0] = sreq;
				end
				ADDR_CREQ: begin
					next_rdata[REQ_W-1:0] = creq;
				end
				ADDR_LAST: begin
					next_rdata[REQ_W-1:0] = last;
				end
				ADDR_IMASK: begin
					next_rdata[EVT_W-1:0] = mask;
				end
				ADDR_ISTAT: begin
					next_rdata[EVT_W-1:0] = stat;
				end
				default: begin
					next_rdata = WORD_0;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			aph         <= '0;
			rdata       <= WORD_0;
			HREADYOUT_O <= 1'h1;
			HRESP_O     <= RESP_OK;
		end else begin
			aph         <= next_aph;
			rdata       <= next_rdata;
			HREADYOUT_O <= 1'h1;
			HRESP_O     <= RESP_OK;
		end
	end

	assign HRDATA_O = rdata;

	// ****************************************
	// Write decode (data phase)
	// ****************************************
	always_comb begin
		wr_gcfg = 1'h0;
		wr_ena  = 1'h0;
		wr_sreq = 1'h0;
		wr_creq = 1'h0;
		wr_last = 1'h0;
		wr_iena = 1'h0;
		wr_idis = 1'h0;
		if (aph.valid && aph.write) begin
			unique case (aph.addr)
				ADDR_GCFG: begin
					wr_gcfg = ~WRITE_PROTECT_ON_I;
				end
				ADDR_ENA: begin
					wr_ena = ~WRITE_PROTECT_ON_I;
				end
				ADDR_SREQ: begin
					wr_sreq = 1'h1;
				end
				ADDR_CREQ: begin
					wr_creq = 1'h1;
				end
				ADDR_LAST: begin
					wr_last = 1'h1;
				end
				ADDR_IENA: begin
					wr_iena = 1'h1;
				end
				ADDR_IDIS: begin
					wr_idis = 1'h1;
				end
				default: begin
					wr_gcfg = 1'h0;
				end
			endcase
		end
	end

	// ****************************************
	// Configuration and enable
	// ****************************************
	always_comb begin
		next_gcfg     = gcfg;
		next_ctrl_ena = ctrl_ena;
		// Low bits are stored as written; software keeps them zero
		if (wr_gcfg) begin
			next_gcfg = HWDATA_I[GCFG_W-1:0];
		end
		if (wr_ena) begin
			next_ctrl_ena = HWDATA_I[ENA_BIT];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			gcfg     <= GCFG_RST;
			ctrl_ena <= 1'h0;
		end else begin
			gcfg     <= next_gcfg;
			ctrl_ena <= next_ctrl_ena;
		end
	end

	// ****************************************
	// Software requests and last flags
	// ****************************************
	// A written one holds until the channel acknowledges it. A new
	// write in the acknowledge cycle wins, so no request is lost.
	always_comb begin
		next_sreq = sreq & ~SINGLE_DONE_I;
		next_creq = creq & ~CHUNK_DONE_I;
		if (wr_sreq) begin
			next_sreq = next_sreq | HWDATA_I[REQ_W-1:0];
		end
		if (wr_creq) begin
			next_creq = next_creq | HWDATA_I[REQ_W-1:0];
		end
		// Flag stays with the request it tags and retires with it
		next_last = last & ~(SINGLE_DONE_I | CHUNK_DONE_I);
		if (wr_last) begin
			next_last = next_last | HWDATA_I[REQ_W-1:0];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			sreq <= REQ_RST;
			creq <= REQ_RST;
			last <= REQ_RST;
		end else begin
			sreq <= next_sreq;
			creq <= next_creq;
			last <= next_last;
		end
	end

	// ****************************************
	// Interrupt mask, status and line
	// ****************************************
	always_comb begin
		next_mask = mask;
		if (wr_iena) begin
			// Ones set, zeros leave the bit alone
			next_mask = mask | HWDATA_I[EVT_W-1:0];
		end
		if (wr_idis) begin
			next_mask = mask & ~HWDATA_I[EVT_W-1:0];
		end
		// Read clears status; an event in that same cycle survives
		next_stat = stat;
		if (rd_take && (HADDR_I == ADDR_ISTAT)) begin
			next_stat = EVT_RST;
		end
		next_stat = next_stat | EVT_I;
		next_irq  = |(next_stat & next_mask);
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			mask <= EVT_RST;
			stat <= EVT_RST;
			irq  <= 1'h0;
		end else begin
			mask <= next_mask;
			stat <= next_stat;
			irq  <= next_irq;
		end
	end

	// ****************************************
	// Outputs to channel logic
	// ****************************************
	assign ARB_POLICY_SEL_O = gcfg[ARB_BIT];
	assign CTRL_ENABLE_O    = ctrl_ena;
	assign SINGLE_REQ_O     = sreq;
	assign CHUNK_REQ_O      = creq;
	assign FINAL_MARKER_O   = last;
	assign IRQ_O            = irq;

endmodule

// >>> src/dgc_pkg.sv
// Constants and carrier types for the DMA global control block.
// Assumes one system clock and a single AHB-Lite master in front of it.
package dgc_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_CH    = 8;
	localparam int REQ_W     = 2 * NUM_CH;
	localparam int EVT_W     = 3 * NUM_CH;
	localparam int GCFG_W    = 5;
	localparam int ARB_BIT   = 4;
	localparam int ENA_BIT   = 0;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [31:0] ADDR_GCFG   = 32'hffffec00;
	localparam logic [31:0] ADDR_ENA    = 32'hffffec04;
	localparam logic [31:0] ADDR_SREQ   = 32'hffffec08;
	localparam logic [31:0] ADDR_CREQ   = 32'hffffec0c;
	localparam logic [31:0] ADDR_LAST   = 32'hffffec10;
	localparam logic [31:0] ADDR_IENA   = 32'hffffec18;
	localparam logic [31:0] ADDR_IDIS   = 32'hffffec1c;
	localparam logic [31:0] ADDR_IMASK  = 32'hffffec20;
	localparam logic [31:0] ADDR_ISTAT  = 32'hffffec24;

	// ****************************************
	// Reset values and bus codes
	// ****************************************
	localparam logic [GCFG_W-1:0] GCFG_RST = 5'h00;
	localparam logic [REQ_W-1:0]  REQ_RST  = 16'h0000;
	localparam logic [EVT_W-1:0]  EVT_RST  = 24'h000000;
	localparam logic [31:0]       WORD_0   = 32'h00000000;
	localparam logic              RESP_OK  = 1'h0;

	// Per-channel events, laid out as in the mask and status words
	typedef struct packed {
		logic [NUM_CH-1:0] bus_access_fault;
		logic [NUM_CH-1:0] chain_done;
		logic [NUM_CH-1:0] buffer_done;
	} dgc_evt_t;

	// Captured address phase of an AHB-Lite transfer
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
	} dgc_aph_t;

endpackage

// >>> bench/dgc_properties.sv
// Port-level checker for dgc_top, bound from the bench top.
// Assumes one clock domain and a single AHB-Lite master.
`timescale 1ns/1ps
module dgc_properties
	import dgc_pkg::*;
(
	input wire logic             SYS_CLK_I,
	input wire logic             RST_B_I,
	input wire logic             HSEL_I,
	input wire logic [31:0]      HADDR_I,
	input wire logic [1:0]       HTRANS_I,
	input wire logic             HWRITE_I,
	input wire logic             HREADY_I,
	input wire logic [31:0]      HWDATA_I,
	input wire logic             WRITE_PROTECT_ON_I,
	input wire logic [REQ_W-1:0] SINGLE_DONE_I,
	input wire logic [31:0]      HRDATA_O,
	input wire logic             ARB_POLICY_SEL_O,
	input wire logic             CTRL_ENABLE_O,
	input wire logic [REQ_W-1:0] SINGLE_REQ_O
);
	// *****
	// Address phase decode
	// *****
	wire aph    = HSEL_I && HTRANS_I[1] && HREADY_I;
	wire rd     = aph && !HWRITE_I;
	wire wr_cfg = aph && HWRITE_I && (HADDR_I == ADDR_GCFG);
	wire wr_ena = aph && HWRITE_I && (HADDR_I == ADDR_ENA);
	wire wr_req = aph && HWRITE_I && (HADDR_I == ADDR_SREQ);

	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);

	chk_wp_blocks: assert property (
		(wr_cfg || wr_ena) ##1 WRITE_PROTECT_ON_I
		|=> $stable(ARB_POLICY_SEL_O) && $stable(CTRL_ENABLE_O)) else $error("protected write landed");
	chk_arb_written: assert property (
		wr_cfg ##1 !WRITE_PROTECT_ON_I
		|=> ARB_POLICY_SEL_O == $past(HWDATA_I[ARB_BIT])) else $error("policy not written");
	chk_ena_written: assert property (
		wr_ena ##1 !WRITE_PROTECT_ON_I
		|=> CTRL_ENABLE_O == $past(HWDATA_I[ENA_BIT])) else $error("enable not written");
	chk_req_raise: assert property ($rose(SINGLE_REQ_O[0]) |-> $past(HWDATA_I[0]))
		else $error("request rose without write");
	chk_req_holds: assert property (SINGLE_REQ_O[1] && !SINGLE_DONE_I[1] |=> SINGLE_REQ_O[1])
		else $error("request lost");
	chk_req_clears: assert property (
		SINGLE_DONE_I[0] && !$past(wr_req) |=> !SINGLE_REQ_O[0]) else $error("request not cleared");
	chk_rdata_idle: assert property (!rd |=> HRDATA_O == WORD_0)
		else $error("read data outside read");
	chk_gcfg_read: assert property (
		rd && HADDR_I == ADDR_GCFG |=> HRDATA_O[ARB_BIT] == $past(ARB_POLICY_SEL_O))
		else $error("policy readback wrong");

	cov_wp_write: cover property (wr_cfg ##1 WRITE_PROTECT_ON_I);
	cov_req_done: cover property (SINGLE_REQ_O[0] && SINGLE_DONE_I[0]);
	cov_cfg_read: cover property (rd && HADDR_I == ADDR_GCFG);
endmodule

// >>> bench/tb.sv
// Self-checking bench for dgc_top: register table, then hand tests.
// Assumes the bench is the only AHB-Lite master and plays the channels.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("ERROR %0t: got %h exp %h", $time, a, e); end end
module tb
	import dgc_pkg::*;
;
	logic             clk = 0;
	logic             rst_b = 0;
	logic             hsel = 0;
	logic [31:0]      haddr = WORD_0;
	logic [1:0]       htrans = 2'h0;
	logic             hwrite = 0;
	logic [31:0]      hwdata = WORD_0;
	logic             wp = 0;
	dgc_evt_t         evt = EVT_RST;
	logic [REQ_W-1:0] sdone = REQ_RST;
	logic [REQ_W-1:0] cdone = REQ_RST;
	logic [31:0]      hrdata, rd;
	logic             hready, hresp, arb, ena, irq;
	logic [REQ_W-1:0] sreq, creq, last;
	int               n_errors = 0;
	int               n_checks = 0;
	// Columns: write offset, write data, read offset, expected read
	logic [23:0]      tbl [10][4] = '{
		'{24'h00, 24'h10, 24'h00, 24'h10}, '{24'h04, 24'h01, 24'h04, 24'h01},
		'{24'h08, 24'h8001, 24'h08, 24'h8001}, '{24'h0c, 24'h0102, 24'h0c, 24'h0102},
		'{24'h10, 24'h4002, 24'h10, 24'h4002}, '{24'h18, 24'h0000ff, 24'h20, 24'h0000ff},
		'{24'h18, 24'h00ff00, 24'h20, 24'h00ffff}, '{24'h18, 24'hff0000, 24'h20, 24'hffffff},
		'{24'h1c, 24'h010101, 24'h20, 24'hfefefe}, '{24'h14, 24'h000001, 24'h14, 24'h000000}};

	always #25 clk = ~clk;

	dgc_top i_dgc_top (.SYS_CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hready),
		.HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.WRITE_PROTECT_ON_I(wp), .EVT_I(evt), .SINGLE_DONE_I(sdone), .CHUNK_DONE_I(cdone),
		.ARB_POLICY_SEL_O(arb), .CTRL_ENABLE_O(ena), .SINGLE_REQ_O(sreq),
		.CHUNK_REQ_O(creq), .FINAL_MARKER_O(last), .IRQ_O(irq));

	// *****
	// Bus master and verdict
	// *****
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= ADDR_GCFG | a;
		do @(posedge clk); while (!hready);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		// Read data is taken at the edge that closes the data phase
		do @(posedge clk); while (!hready);
		rd = hrdata;
	endtask

	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#100000;
		n_errors++;
		summarize;
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		@(negedge clk);
		`CHK({hready, hresp, arb, ena, irq, sreq, creq, last, hrdata}, {1'h1, 84'h0})
		@(posedge clk);
		bus(1'h0, 8'h20, WORD_0);
		`CHK(rd, WORD_0)
		$display("reset test done");
		foreach (tbl[i]) begin
			bus(1'h1, tbl[i][0][7:0], {8'h00, tbl[i][1]});
			bus(1'h0, tbl[i][2][7:0], WORD_0);
			`CHK(rd, {8'h00, tbl[i][3]})
		end
		`CHK({arb, ena, sreq, creq, last}, 50'h3_8001_0102_4002)
		$display("table test done");
		wp <= 1'h1;
		bus(1'h1, 8'h00, WORD_0);
		bus(1'h1, 8'h04, WORD_0);
		wp <= 1'h0;
		bus(1'h1, 8'h00, WORD_0);
		@(negedge clk);
		`CHK({arb, ena}, 2'h1)
		$display("protect test done");
		@(posedge clk);
		sdone <= 16'h8001;
		cdone <= 16'h0002;
		@(posedge clk);
		sdone <= REQ_RST;
		cdone <= REQ_RST;
		evt <= 24'h000001;
		@(negedge clk);
		`CHK({sreq, creq, last}, 48'h0000_0100_4000)
		$display("ack test done");
		@(posedge clk);
		evt <= 24'h020002;
		@(negedge clk);
		`CHK(irq, 1'h0)
		@(posedge clk);
		evt <= EVT_RST;
		@(negedge clk);
		`CHK(irq, 1'h1)
		@(posedge clk);
		bus(1'h0, 8'h24, WORD_0);
		`CHK(rd, 32'h00020003)
		@(negedge clk);
		`CHK(irq, 1'h0)
		$display("irq test done");
		summarize;
	end
endmodule

bind dgc_top dgc_properties i_chk (.SYS_CLK_I, .RST_B_I, .HSEL_I, .HADDR_I, .HTRANS_I,
	.HWRITE_I, .HREADY_I, .HWDATA_I, .WRITE_PROTECT_ON_I, .SINGLE_DONE_I, .HRDATA_O,
	.ARB_POLICY_SEL_O, .CTRL_ENABLE_O, .SINGLE_REQ_O);
